// file: gpd_port_top.sv
// GPIO data and direction registers for ports B and C, port A drive
// enables, pullup enables and strong drive control, behind AXI4-Lite.
// Assumes pin inputs are asynchronous and the pad resolves level from
// the drive value and drive enable outputs.
`timescale 1ns/1ps
`include "gpd_map.svh"

module gpd_port_top
   import gpd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axil_awaddr,
   input wire logic s_axil_awvalid,
   output logic s_axil_awready,
   input wire logic [31:0] s_axil_wdata,
   input wire logic [3:0] s_axil_wstrb,
   input wire logic s_axil_wvalid,
   output logic s_axil_wready,
   output logic [1:0] s_axil_bresp,
   output logic s_axil_bvalid,
   input wire logic s_axil_bready,
   input wire logic [31:0] s_axil_araddr,
   input wire logic s_axil_arvalid,
   output logic s_axil_arready,
   output logic [31:0] s_axil_rdata,
   output logic [1:0] s_axil_rresp,
   output logic s_axil_rvalid,
   input wire logic s_axil_rready,
   output logic [`GPD_PORT_A_W-1:0] port_a_drive_enable_bits,
   output logic [`GPD_PORT_A_W-1:0] port_a_pullup_on,
   input wire logic [`GPD_PORT_B_W-1:0] port_b_pin_in,
   output logic [`GPD_PORT_B_W-1:0] port_b_data_bits,
   output logic [`GPD_PORT_B_W-1:0] port_b_drive_enable_bits,
   output logic [`GPD_PORT_B_W-1:0] port_b_pullup_on,
   output logic port_b_pin_four_strong,
   output logic port_b_pin_five_strong,
   input wire logic [`GPD_PORT_C_W-1:0] port_c_pin_in,
   output logic [`GPD_PORT_C_W-1:0] port_c_data_bits,
   output logic [`GPD_PORT_C_W-1:0] port_c_drive_enable_bits,
   output logic [`GPD_PORT_C_W-1:0] port_c_pullup_on
);
   // =====================================================================
   // Bus front end and pin synchronisers
   // =====================================================================
   gpd_reg_if regs ();

   gpd_axil_slave u_slave (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axil_awaddr(s_axil_awaddr),
      .s_axil_awvalid(s_axil_awvalid),
      .s_axil_awready(s_axil_awready),
      .s_axil_wdata(s_axil_wdata),
      .s_axil_wstrb(s_axil_wstrb),
      .s_axil_wvalid(s_axil_wvalid),
      .s_axil_wready(s_axil_wready),
      .s_axil_bresp(s_axil_bresp),
      .s_axil_bvalid(s_axil_bvalid),
      .s_axil_bready(s_axil_bready),
      .s_axil_araddr(s_axil_araddr),
      .s_axil_arvalid(s_axil_arvalid),
      .s_axil_arready(s_axil_arready),
      .s_axil_rdata(s_axil_rdata),
      .s_axil_rresp(s_axil_rresp),
      .s_axil_rvalid(s_axil_rvalid),
      .s_axil_rready(s_axil_rready),
      .regs(regs.slave_side)
   );

   logic [`GPD_PORT_B_W-1:0] port_b_level;
   logic [`GPD_PORT_C_W-1:0] port_c_level;

   gpd_sync #(.WIDTH(`GPD_PORT_B_W)) u_sync_b (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(port_b_pin_in),
      .sync_out(port_b_level)
   );

   gpd_sync #(.WIDTH(`GPD_PORT_C_W)) u_sync_c (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(port_c_pin_in),
      .sync_out(port_c_level)
   );

   // =====================================================================
   // Register storage
   // =====================================================================
   logic [`GPD_PORT_B_W-1:0] pb_data_reg;
   logic [`GPD_PORT_C_W-1:0] pc_data_reg;
   logic [`GPD_DRIVE_W-1:0] drive_reg;
   logic [`GPD_PORT_A_W-1:0] pa_oe_reg;
   logic [`GPD_PORT_B_W-1:0] pb_oe_reg;
   logic [`GPD_PORT_C_W-1:0] pc_oe_reg;
   logic [`GPD_PORT_B_W-1:0] pb_ie_reg;
   logic [`GPD_PORT_C_W-1:0] pc_ie_reg;
   logic [`GPD_PORT_A_W-1:0] pa_pe_reg;
   logic [`GPD_PORT_B_W-1:0] pb_pe_reg;
   logic [`GPD_PORT_C_W-1:0] pc_pe_reg;
   gpd_sel_t wr_sel;
   gpd_sel_t rd_sel;

   assign wr_sel = gpd_decode(regs.wr_addr);
   assign rd_sel = gpd_decode(regs.rd_addr);
   assign regs.wr_err = (wr_sel == GPD_SEL_NONE);

   // Data is stored whatever the direction, so a value can be staged
   // before its drive enable is set and no stale level reaches the pin.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pb_data_reg <= '0;
         pc_data_reg <= '0;
      end else if (regs.wr_en) begin
         if (wr_sel == GPD_SEL_PORT_B_DATA) begin
            pb_data_reg <= regs.wr_data;
         end
         if (wr_sel == GPD_SEL_PORT_C_DATA) begin
            pc_data_reg <= regs.wr_data[`GPD_PORT_C_W-1:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pa_oe_reg <= '0;
         pb_oe_reg <= '0;
         pc_oe_reg <= '0;
      end else if (regs.wr_en) begin
         if (wr_sel == GPD_SEL_PORT_A_OE) begin
            pa_oe_reg <= regs.wr_data[`GPD_PORT_A_W-1:0];
         end
         if (wr_sel == GPD_SEL_PORT_B_OE) begin
            pb_oe_reg <= regs.wr_data;
         end
         if (wr_sel == GPD_SEL_PORT_C_OE) begin
            pc_oe_reg <= regs.wr_data[`GPD_PORT_C_W-1:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pb_ie_reg <= '0;
         pc_ie_reg <= '0;
      end else if (regs.wr_en) begin
         if (wr_sel == GPD_SEL_PORT_B_IE) begin
            pb_ie_reg <= regs.wr_data;
         end
         if (wr_sel == GPD_SEL_PORT_C_IE) begin
            pc_ie_reg <= regs.wr_data[`GPD_PORT_C_W-1:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pa_pe_reg <= '0;
         pb_pe_reg <= '0;
         pc_pe_reg <= '0;
      end else if (regs.wr_en) begin
         if (wr_sel == GPD_SEL_PORT_A_PE) begin
            pa_pe_reg <= regs.wr_data[`GPD_PORT_A_W-1:0];
         end
         if (wr_sel == GPD_SEL_PORT_B_PE) begin
            pb_pe_reg <= regs.wr_data;
         end
         if (wr_sel == GPD_SEL_PORT_C_PE) begin
            pc_pe_reg <= regs.wr_data[`GPD_PORT_C_W-1:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drive_reg <= '0;
      end else if (regs.wr_en && wr_sel == GPD_SEL_STRONG_DRIVE) begin
         drive_reg <= regs.wr_data[`GPD_DRIVE_W-1:0];
      end
   end

   // =====================================================================
   // Read-back of the data, drive enable, input enable, pullup and strong drive registers
   // =====================================================================
   // The drive enable decides the source even when the input path is on;
   // a pin with neither enable reads zero here, a value software must
   // not rely on.
   logic [`GPD_PORT_B_W-1:0] pb_read;
   logic [`GPD_PORT_C_W-1:0] pc_read;

   for (genvar i = 0; i < `GPD_PORT_B_W; i++) begin : g_pb_read
      assign pb_read[i] = pb_oe_reg[i] ? pb_data_reg[i] :
         (pb_ie_reg[i] & port_b_level[i]);
   end

   for (genvar i = 0; i < `GPD_PORT_C_W; i++) begin : g_pc_read
      assign pc_read[i] = pc_oe_reg[i] ? pc_data_reg[i] :
         (pc_ie_reg[i] & port_c_level[i]);
   end

   always_comb begin
      regs.rd_err = 1'b0;
      regs.rd_data = `GPD_RESET_BYTE;
      unique case (rd_sel)
         GPD_SEL_PORT_B_DATA: regs.rd_data = pb_read;
         GPD_SEL_PORT_C_DATA: regs.rd_data = {4'h0, pc_read};
         GPD_SEL_STRONG_DRIVE: regs.rd_data = {6'h00, drive_reg};
         GPD_SEL_PORT_A_OE: regs.rd_data = {2'h0, pa_oe_reg};
         GPD_SEL_PORT_B_OE: regs.rd_data = pb_oe_reg;
         GPD_SEL_PORT_C_OE: regs.rd_data = {4'h0, pc_oe_reg};
         GPD_SEL_PORT_B_IE: regs.rd_data = pb_ie_reg;
         GPD_SEL_PORT_C_IE: regs.rd_data = {4'h0, pc_ie_reg};
         GPD_SEL_PORT_A_PE: regs.rd_data = {2'h0, pa_pe_reg};
         GPD_SEL_PORT_B_PE: regs.rd_data = pb_pe_reg;
         GPD_SEL_PORT_C_PE: regs.rd_data = {4'h0, pc_pe_reg};
         GPD_SEL_NONE: regs.rd_err = 1'b1;
      endcase
   end

   // =====================================================================
   // Pin side
   // =====================================================================
   // Drive value and enable come straight from their registers, so a
   // write shows on the pins at the edge that completes it.
   assign port_b_data_bits = pb_data_reg;
   assign port_c_data_bits = pc_data_reg;
   assign port_a_drive_enable_bits = pa_oe_reg;
   assign port_b_drive_enable_bits = pb_oe_reg;
   assign port_c_drive_enable_bits = pc_oe_reg;

   // Derived pad controls are registered; they trail the register write
   // by one cycle, which only delays a pullup or drive-strength change.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_a_pullup_on <= '0;
         port_b_pullup_on <= '0;
         port_c_pullup_on <= '0;
      end else begin
         port_a_pullup_on <= pa_pe_reg & ~pa_oe_reg;
         port_b_pullup_on <= pb_pe_reg & ~pb_oe_reg;
         port_c_pullup_on <= pc_pe_reg & ~pc_oe_reg;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_b_pin_four_strong <= 1'b0;
         port_b_pin_five_strong <= 1'b0;
      end else begin
         port_b_pin_four_strong <= drive_reg[`GPD_DRIVE_PIN_FOUR] &
            pb_oe_reg[`GPD_PIN_FOUR];
         port_b_pin_five_strong <= drive_reg[`GPD_DRIVE_PIN_FIVE] &
            pb_oe_reg[`GPD_PIN_FIVE];
      end
   end
endmodule

// file: gpd_map.svh
// Register indices, field widths, reset values and bus codes for the
// GPIO data and direction block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef GPD_MAP_SVH
`define GPD_MAP_SVH

// Register indices; the AXI4-Lite byte address is four times the index.
`define GPD_IDX_PORT_B_DATA 14'h0001
`define GPD_IDX_PORT_C_DATA 14'h0002
`define GPD_IDX_STRONG_DRIVE 14'h30af
`define GPD_IDX_PORT_A_OE 14'h30b0
`define GPD_IDX_PORT_B_OE 14'h30b1
`define GPD_IDX_PORT_C_OE 14'h30b2
`define GPD_IDX_PORT_B_IE 14'h30b9
`define GPD_IDX_PORT_C_IE 14'h30ba
`define GPD_IDX_PORT_A_PE 14'h30f0
`define GPD_IDX_PORT_B_PE 14'h30f1
`define GPD_IDX_PORT_C_PE 14'h30f2

// Implemented widths of each port.
`define GPD_PORT_A_W 6
`define GPD_PORT_B_W 8
`define GPD_PORT_C_W 4
`define GPD_DRIVE_W 2

// Field positions inside the strong drive register and of the port B pins it controls.
`define GPD_DRIVE_PIN_FOUR 0
`define GPD_DRIVE_PIN_FIVE 1
`define GPD_PIN_FOUR 4
`define GPD_PIN_FIVE 5

`define GPD_RESET_BYTE 8'h00
`define GPD_RESP_OKAY 2'h0
`define GPD_RESP_SLVERR 2'h2

`endif

// file: gpd_pkg.sv
// Types shared by the GPIO data and direction block.
// Assumes gpd_map.svh is on the include path.
`include "gpd_map.svh"

package gpd_pkg;

   typedef logic [7:0] gpd_byte_t;

   typedef enum {
      GPD_SEL_NONE,
      GPD_SEL_PORT_B_DATA,
      GPD_SEL_PORT_C_DATA,
      GPD_SEL_STRONG_DRIVE,
      GPD_SEL_PORT_A_OE,
      GPD_SEL_PORT_B_OE,
      GPD_SEL_PORT_C_OE,
      GPD_SEL_PORT_B_IE,
      GPD_SEL_PORT_C_IE,
      GPD_SEL_PORT_A_PE,
      GPD_SEL_PORT_B_PE,
      GPD_SEL_PORT_C_PE
   } gpd_sel_t;

   // Any address outside the low 64 KiB, or not word aligned, is unmapped.
   function automatic gpd_sel_t gpd_decode(input logic [31:0] addr);
      gpd_sel_t sel;
      sel = GPD_SEL_NONE;
      if (addr[31:16] == 16'h0000 && addr[1:0] == 2'h0) begin
         unique case (addr[15:2])
            `GPD_IDX_PORT_B_DATA: sel = GPD_SEL_PORT_B_DATA;
            `GPD_IDX_PORT_C_DATA: sel = GPD_SEL_PORT_C_DATA;
            `GPD_IDX_STRONG_DRIVE: sel = GPD_SEL_STRONG_DRIVE;
            `GPD_IDX_PORT_A_OE: sel = GPD_SEL_PORT_A_OE;
            `GPD_IDX_PORT_B_OE: sel = GPD_SEL_PORT_B_OE;
            `GPD_IDX_PORT_C_OE: sel = GPD_SEL_PORT_C_OE;
            `GPD_IDX_PORT_B_IE: sel = GPD_SEL_PORT_B_IE;
            `GPD_IDX_PORT_C_IE: sel = GPD_SEL_PORT_C_IE;
            `GPD_IDX_PORT_A_PE: sel = GPD_SEL_PORT_A_PE;
            `GPD_IDX_PORT_B_PE: sel = GPD_SEL_PORT_B_PE;
            `GPD_IDX_PORT_C_PE: sel = GPD_SEL_PORT_C_PE;
            default: sel = GPD_SEL_NONE;
         endcase
      end
      return sel;
   endfunction

endpackage

// file: gpd_reg_if.sv
// Internal register access path between the bus slave and the register file.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface gpd_reg_if;
   import gpd_pkg::*;

   logic wr_en;
   logic [31:0] wr_addr;
   gpd_byte_t wr_data;
   logic wr_err;
   logic [31:0] rd_addr;
   gpd_byte_t rd_data;
   logic rd_err;

   modport slave_side (
      output wr_en,
      output wr_addr,
      output wr_data,
      input wr_err,
      output rd_addr,
      input rd_data,
      input rd_err
   );

   modport regs_side (
      input wr_en,
      input wr_addr,
      input wr_data,
      output wr_err,
      input rd_addr,
      output rd_data,
      output rd_err
   );
endinterface

// file: gpd_sync.sv
// Two flip-flop synchroniser for a group of pin levels.
// Assumes the pins are asynchronous to aclk; only the second stage is read.
`timescale 1ns/1ps

module gpd_sync #(
   parameter int WIDTH = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// file: gpd_axil_slave.sv
// AXI4-Lite slave front end: holds write address and data, issues one register
// access per transaction and returns the response a cycle later.
// Assumes a register file that answers in the same cycle it is addressed.
`timescale 1ns/1ps
`include "gpd_map.svh"

module gpd_axil_slave
   import gpd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axil_awaddr,
   input wire logic s_axil_awvalid,
   output logic s_axil_awready,
   input wire logic [31:0] s_axil_wdata,
   input wire logic [3:0] s_axil_wstrb,
   input wire logic s_axil_wvalid,
   output logic s_axil_wready,
   output logic [1:0] s_axil_bresp,
   output logic s_axil_bvalid,
   input wire logic s_axil_bready,
   input wire logic [31:0] s_axil_araddr,
   input wire logic s_axil_arvalid,
   output logic s_axil_arready,
   output logic [31:0] s_axil_rdata,
   output logic [1:0] s_axil_rresp,
   output logic s_axil_rvalid,
   input wire logic s_axil_rready,
   gpd_reg_if.slave_side regs
);
   logic aw_held_reg;
   logic w_held_reg;
   logic [31:0] awaddr_reg;
   logic [7:0] wdata_reg;
   logic wstrb0_reg;
   logic wr_fire;
   logic ar_fire;

   // =====================================================================
   // Write path
   // =====================================================================
   assign wr_fire = aw_held_reg && w_held_reg && !s_axil_bvalid;
   // A write with byte lane 0 cleared stores nothing but still answers.
   assign regs.wr_en = wr_fire && wstrb0_reg;
   assign regs.wr_addr = awaddr_reg;
   assign regs.wr_data = wdata_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         awaddr_reg <= '0;
         s_axil_awready <= 1'b0;
      end else begin
         s_axil_awready <= 1'b0;
         if (s_axil_awvalid && s_axil_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axil_awaddr;
         end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
         end else if (!aw_held_reg && s_axil_awvalid && !s_axil_awready) begin
            s_axil_awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         wdata_reg <= `GPD_RESET_BYTE;
         wstrb0_reg <= 1'b0;
         s_axil_wready <= 1'b0;
      end else begin
         s_axil_wready <= 1'b0;
         if (s_axil_wvalid && s_axil_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axil_wdata[7:0];
            wstrb0_reg <= s_axil_wstrb[0];
         end else if (wr_fire) begin
            w_held_reg <= 1'b0;
         end else if (!w_held_reg && s_axil_wvalid && !s_axil_wready) begin
            s_axil_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axil_bvalid <= 1'b0;
         s_axil_bresp <= `GPD_RESP_OKAY;
      end else if (wr_fire) begin
         s_axil_bvalid <= 1'b1;
         s_axil_bresp <= regs.wr_err ? `GPD_RESP_SLVERR : `GPD_RESP_OKAY;
      end else if (s_axil_bready) begin
         s_axil_bvalid <= 1'b0;
      end
   end

   // =====================================================================
   // Read path
   // =====================================================================
   assign ar_fire = s_axil_arvalid && s_axil_arready;
   assign regs.rd_addr = s_axil_araddr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axil_arready <= 1'b0;
         s_axil_rvalid <= 1'b0;
         s_axil_rdata <= '0;
         s_axil_rresp <= `GPD_RESP_OKAY;
      end else begin
         s_axil_arready <= 1'b0;
         if (ar_fire) begin
            s_axil_rvalid <= 1'b1;
            s_axil_rdata <= {24'h000000, regs.rd_data};
            s_axil_rresp <= regs.rd_err ? `GPD_RESP_SLVERR : `GPD_RESP_OKAY;
         end else if (s_axil_rvalid) begin
            if (s_axil_rready) begin
               s_axil_rvalid <= 1'b0;
            end
         end else if (s_axil_arvalid && !s_axil_arready) begin
            s_axil_arready <= 1'b1;
         end
      end
   end
endmodule

// file: gpd_port_monitor.sv
// Port checks for the GPIO data and direction block.
// Assumes a bind to gpd_port_top, one clock and a synchronous reset.
`timescale 1ns/1ps
// ==========
// Checker
module gpd_port_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axil_awvalid,
   input wire logic s_axil_awready,
   input wire logic s_axil_wvalid,
   input wire logic s_axil_wready,
   input wire logic [1:0] s_axil_bresp,
   input wire logic s_axil_bvalid,
   input wire logic s_axil_bready,
   input wire logic s_axil_arvalid,
   input wire logic s_axil_arready,
   input wire logic [31:0] s_axil_rdata,
   input wire logic [1:0] s_axil_rresp,
   input wire logic s_axil_rvalid,
   input wire logic s_axil_rready,
   input wire logic [5:0] port_a_drive_enable_bits,
   input wire logic [5:0] port_a_pullup_on,
   input wire logic [7:0] port_b_drive_enable_bits,
   input wire logic [7:0] port_b_pullup_on,
   input wire logic port_b_pin_four_strong,
   input wire logic port_b_pin_five_strong
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_reset_quiet: assert property (disable iff (1'h0)
      !aresetn |=> !s_axil_bvalid && !s_axil_rvalid
      && port_a_drive_enable_bits == 6'h0 && port_a_pullup_on == 6'h0
      && port_b_drive_enable_bits == 8'h0 && port_b_pullup_on == 8'h0
      && !port_b_pin_four_strong && !port_b_pin_five_strong)
      else $error("outputs active after reset");
   // The pullup lags its enable by a cycle, so only settled outputs count.
   a_pullup_off: assert property (
      (port_b_pullup_on & port_b_drive_enable_bits
      & $past(port_b_drive_enable_bits)) == 8'h0
      && (port_a_pullup_on & port_a_drive_enable_bits
      & $past(port_a_drive_enable_bits)) == 6'h0)
      else $error("pullup on while pin drives");
   a_strong_four: assert property (
      port_b_pin_four_strong |->
      ($past(port_b_drive_enable_bits) & 8'h10) != 8'h0)
      else $error("pin four strong while input");
   a_strong_five: assert property (
      port_b_pin_five_strong |->
      ($past(port_b_drive_enable_bits) & 8'h20) != 8'h0)
      else $error("pin five strong while input");
   a_write_answer: assert property (
      s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready
      |-> ##2 s_axil_bvalid)
      else $error("write answer late");
   a_read_answer: assert property (
      s_axil_arvalid && s_axil_arready |=> s_axil_rvalid ##1 1'h1)
      else $error("read answer late");
   a_ar_pulse: assert property (
      s_axil_arready |=> !s_axil_arready)
      else $error("arready held");
   a_b_hold: assert property (
      s_axil_bvalid && !s_axil_bready |=>
      s_axil_bvalid && $stable(s_axil_bresp))
      else $error("write answer dropped");
   a_r_hold: assert property (
      s_axil_rvalid && !s_axil_rready |=>
      s_axil_rvalid && $stable(s_axil_rdata))
      else $error("read answer dropped");
   a_upper_zero: assert property (
      s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_error_zero: assert property (
      s_axil_rvalid && s_axil_rresp == 2'h2 |-> s_axil_rdata == 32'h0)
      else $error("error read data not zero");
   c_write: cover property (s_axil_bvalid && s_axil_bready);
   c_read: cover property (s_axil_rvalid && s_axil_rready);
   c_error: cover property (s_axil_rvalid && s_axil_rresp == 2'h2);
   c_strong: cover property (port_b_pin_four_strong);
endmodule

// file: gpd_pin_model.sv
// Board side of the port pins.
// Assumes a drive enable that is high while the block drives the pin.
`timescale 1ns/1ps
// ==========
// Pin levels
module gpd_pin_model (
   input wire logic [7:0] b_oe,
   input wire logic [7:0] b_drv,
   input wire logic [7:0] b_bd,
   output logic [7:0] b_pin,
   input wire logic [3:0] c_oe,
   input wire logic [3:0] c_drv,
   input wire logic [3:0] c_bd,
   output logic [3:0] c_pin
);
   // The board backs off where the block drives, so no pin floats.
   assign b_pin = (b_oe & b_drv) | (~b_oe & b_bd);
   assign c_pin = (c_oe & c_drv) | (~c_oe & c_bd);
endmodule

// file: gpd_port_top_tb.sv
// Self-checking bench for the GPIO data and direction block.
// Assumes the package, design, pin model and checker compile first.
`timescale 1ns/1ps
// ==========
// Bench
module gpd_port_top_tb;
   import gpd_pkg::*;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [31:0] s_axil_awaddr = 32'h0;
   logic [31:0] s_axil_wdata = 32'h0;
   logic [31:0] s_axil_araddr = 32'h0;
   logic [31:0] s_axil_rdata;
   logic [3:0] s_axil_wstrb = 4'hf;
   logic [1:0] s_axil_bresp, s_axil_rresp;
   logic s_axil_awvalid = 1'h0;
   logic s_axil_wvalid = 1'h0;
   logic s_axil_bready = 1'h0;
   logic s_axil_arvalid = 1'h0;
   logic s_axil_rready = 1'h0;
   logic s_axil_awready, s_axil_wready, s_axil_bvalid;
   logic s_axil_arready, s_axil_rvalid;
   logic [5:0] port_a_drive_enable_bits, port_a_pullup_on;
   logic [7:0] port_b_pin_in, port_b_data_bits, port_b_pullup_on;
   logic [7:0] port_b_drive_enable_bits;
   logic [7:0] bd_b = 8'h0;
   logic port_b_pin_four_strong, port_b_pin_five_strong;
   logic [3:0] port_c_pin_in, port_c_data_bits, port_c_pullup_on;
   logic [3:0] port_c_drive_enable_bits;
   logic [3:0] bd_c = 4'h0;
   int n_mismatch = 0;
   int comparisons = 0;
   int st [11];
   logic [31:0] ad [11] = '{32'h4, 32'h8, 32'hc2bc, 32'hc2c0, 32'hc2c4,
      32'hc2c8, 32'hc2e4, 32'hc2e8, 32'hc3c0, 32'hc3c4, 32'hc3c8};
   logic [7:0] msk [11] = '{8'hff, 8'h0f, 8'h03, 8'h3f, 8'hff, 8'h0f,
      8'hff, 8'h0f, 8'h3f, 8'hff, 8'h0f};
   logic [31:0] bad [3] = '{32'h10, 32'h10004, 32'h5};
   gpd_port_top dut (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid,
      .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid,
      .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
      .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
      .s_axil_rresp, .s_axil_rvalid, .s_axil_rready,
      .port_a_drive_enable_bits, .port_a_pullup_on, .port_b_pin_in,
      .port_b_data_bits, .port_b_drive_enable_bits, .port_b_pullup_on,
      .port_b_pin_four_strong, .port_b_pin_five_strong, .port_c_pin_in,
      .port_c_data_bits, .port_c_drive_enable_bits, .port_c_pullup_on);
   gpd_pin_model pins (.b_oe(port_b_drive_enable_bits),
      .b_drv(port_b_data_bits), .b_bd(bd_b), .b_pin(port_b_pin_in),
      .c_oe(port_c_drive_enable_bits), .c_drv(port_c_data_bits),
      .c_bd(bd_c), .c_pin(port_c_pin_in));
   always #4 aclk = ~aclk;
   task automatic chk_val(string nm, logic [31:0] e, logic [31:0] g,
      logic [31:0] c = 32'hffffffff);
      comparisons++;
      if ((g & c) !== (e & c)) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_resp(string nm, logic [1:0] e, logic [1:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [31:0] a, logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      s_axil_awaddr <= a;
      s_axil_wdata <= d;
      s_axil_awvalid <= 1'h1;
      s_axil_wvalid <= 1'h1;
      s_axil_bready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axil_awready === 1'h1) s_axil_awvalid <= 1'h0;
         if (s_axil_wready === 1'h1) s_axil_wvalid <= 1'h0;
      end while (!(s_axil_bvalid === 1'h1 && s_axil_bready) && n < 64);
      r = s_axil_bresp;
      s_axil_bready <= 1'h0;
      if (n >= 64) n_mismatch++;
   endtask
   task automatic rd(logic [31:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      s_axil_araddr <= a;
      s_axil_arvalid <= 1'h1;
      s_axil_rready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axil_arready === 1'h1) s_axil_arvalid <= 1'h0;
      end while (!(s_axil_rvalid === 1'h1 && s_axil_rready) && n < 64);
      d = s_axil_rdata;
      r = s_axil_rresp;
      s_axil_rready <= 1'h0;
      if (n >= 64) n_mismatch++;
   endtask
   task automatic wreg(int i, int v);
      logic [1:0] r;
      wr(ad[i], v, r);
      chk_resp("bresp", 2'h0, r);
      if (s_axil_wstrb[0]) st[i] = v & msk[i];
   endtask
   // Pins that neither drive nor sense read zero, a value not to rely on, so they are masked.
   function automatic void exp_rd(int i, output logic [31:0] e, c);
      int oe, ie, pin;
      e = st[i];
      c = 32'hffffffff;
      if (i < 2) begin
         oe = st[i + 4];
         ie = st[i + 6];
         pin = (i == 0) ? bd_b : bd_c;
         e = (oe & st[i]) | (~oe & ie & pin);
         c = {24'hffffff, 8'(oe | ie | ~msk[i])};
      end
   endfunction
   task automatic rd_all();
      logic [31:0] d, e, c;
      logic [1:0] r;
      for (int i = 0; i < 11; i++) begin
         rd(ad[i], d, r);
         exp_rd(i, e, c);
         chk_resp("rresp", 2'h0, r);
         chk_val("read data", e, d, c);
      end
   endtask
   task automatic pin_chk();
      chk_val("b data", st[0], port_b_data_bits);
      chk_val("c data", st[1], port_c_data_bits);
      chk_val("a oe", st[3], port_a_drive_enable_bits);
      chk_val("b oe", st[4], port_b_drive_enable_bits);
      chk_val("c oe", st[5], port_c_drive_enable_bits);
      chk_val("a pull", st[8] & ~st[3], port_a_pullup_on);
      chk_val("b pull", st[9] & ~st[4], port_b_pullup_on);
      chk_val("c pull", st[10] & ~st[5], port_c_pullup_on);
      chk_val("strong", st[2] & (st[4] >> 4),
         {port_b_pin_five_strong, port_b_pin_four_strong});
   endtask
   task automatic rst_run();
      aresetn <= 1'h0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      st = '{default: 0};
      @(posedge aclk);
      pin_chk();
      rd_all();
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      logic [1:0] r;
      logic [31:0] d;
      void'($urandom(32'ha3f33064));
      rst_run();
      $display("test reset done");
      repeat (12) begin
         s_axil_wstrb <= 4'($urandom);
         for (int i = 0; i < 11; i++) wreg(i, $urandom);
         bd_b <= 8'($urandom);
         bd_c <= 4'($urandom);
         repeat (4) @(posedge aclk);
         pin_chk();
         rd_all();
      end
      $display("test random done");
      for (int k = 0; k < 3; k++) begin
         wr(bad[k], $urandom, r);
         chk_resp("bresp", 2'h2, r);
         rd(bad[k], d, r);
         chk_resp("rresp", 2'h2, r);
         chk_val("error data", 32'h0, d);
      end
      rd_all();
      $display("test unmapped done");
      rst_run();
      $display("test second reset done");
      end_sim();
   end
   initial begin
      #100000;
      n_mismatch++;
      end_sim();
   end
endmodule
bind gpd_port_top gpd_port_monitor mon (.aclk, .aresetn, .s_axil_awvalid,
   .s_axil_awready, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
   .s_axil_bvalid, .s_axil_bready, .s_axil_arvalid, .s_axil_arready,
   .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready,
   .port_a_drive_enable_bits, .port_a_pullup_on, .port_b_drive_enable_bits,
   .port_b_pullup_on, .port_b_pin_four_strong, .port_b_pin_five_strong);
